// *** bench/mafpm_checker.sv ***
// concurrent checks on the ports of the filter and phy management block
`timescale 1ns/1ps
`default_nettype none
module mafpm_checker #(
    parameter int DIV_HALF = 2
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire mafpm_pkg::mafpm_rx_req_t rx_req,
    input wire mafpm_pkg::mafpm_rx_res_t rx_res,
    input wire mafpm_pkg::mafpm_mdio_drv_t mdio_drv,
    input wire logic phy_access_busy
);
    // a frame is 64 mdc periods; slack covers start and finish latency
    localparam int BMIN = 128 * DIV_HALF - 4;
    localparam int BMAX = 128 * DIV_HALF + 8;
    logic [15:0] busy_cnt_ff;
    logic [15:0] nxt_busy_cnt;
    logic go;
    assign nxt_busy_cnt = phy_access_busy ? busy_cnt_ff + 16'h0001 : 16'h0;
    assign go = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_dat_i[0] && !phy_access_busy && wb_adr_i == 12'h114;
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n) busy_cnt_ff <= 16'h0;
        else busy_cnt_ff <= nxt_busy_cnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("bus request not acknowledged next cycle");
    property p_rx_done;
        rx_req.valid |=> rx_res.done;
    endproperty
    a_rx_done: assert property (p_rx_done)
        else $error("destination check gave no result");
    property p_rx_hold;
        !rx_res.done |-> $stable(rx_res.accept) && $stable(rx_res.hash_idx);
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("filter result changed without a request");
    property p_rx_group;
        rx_res.done |-> rx_res.group == $past(rx_req.dest[0]);
    endproperty
    a_rx_group: assert property (p_rx_group)
        else $error("group flag does not follow destination bit 0");
    property p_busy_start;
        go |-> ##[1:3] phy_access_busy;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy not raised after start write");
    property p_busy_min;
        $fell(phy_access_busy) |-> busy_cnt_ff >= BMIN;
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("busy cleared before the frame could finish");
    property p_busy_max;
        busy_cnt_ff <= BMAX;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("busy held past one frame");
    property p_mdio_edge;
        $changed(mdio_drv.mdio_out) && mdio_drv.mdio_oe
            && $past(mdio_drv.mdio_oe) |-> $fell(mdio_drv.mdc);
    endproperty
    a_mdio_edge: assert property (p_mdio_edge)
        else $error("management data moved away from the falling clock");
endmodule // mafpm_checker
bind mafpm_top mafpm_checker #(.DIV_HALF(DIV_HALF)) mafpm_checker_inst (
    .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .rx_req(rx_req), .rx_res(rx_res), .mdio_drv(mdio_drv),
    .phy_access_busy(phy_access_busy));
`default_nettype wire

// *** bench/mafpm_phy_model.sv ***
// behavioural phy management register set seen across the mdio wire
`timescale 1ns/1ps
`default_nettype none
module mafpm_phy_model (
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    output logic mdio_wire
);
    logic [15:0] regs [32];
    logic [63:0] fr;
    logic drv_en, drv_bit, rd, wr;
    logic [4:0] ra;
    int idx;
    // a released line floats to the pull-up level
    assign mdio_wire = drv_en ? drv_bit : (mdio_oe ? mdio_out : 1'h1);
    initial begin
        {drv_en, drv_bit, rd, wr, ra, fr} = '0;
        idx = 100;
        foreach (regs[i]) regs[i] = 16'hc3a0 + 16'(i);
    end
    // frame starts when the station begins driving
    always @(posedge mdio_oe) idx = 0;
    always @(posedge mdc) begin
        fr = {fr[62:0], mdio_wire};
        if (idx == 45) begin
            ra = fr[4:0];
            rd = fr[45:5] == {32'hffff_ffff, 9'h0c1};
            wr = fr[45:5] == {32'hffff_ffff, 9'h0a1};
        end
        if (rd && idx >= 46 && idx <= 62) begin
            drv_en <= 1'h1;
            drv_bit <= idx == 46 ? 1'h0 : regs[ra][62 - idx];
        end
        if (idx == 63) begin
            if (wr) regs[ra] = fr[15:0];
            drv_en <= 1'h0;
            {rd, wr} = 2'h0;
        end
        idx = idx + 1;
    end
endmodule // mafpm_phy_model
`default_nettype wire

// *** bench/mafpm_top_tb.sv ***
// self-checking bench for the address filter and phy management block
`timescale 1ns/1ps
`default_nettype none
module mafpm_top_tb;
    logic core_clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack, mdio_w, busy;
    logic [11:0] wb_adr;
    logic [3:0] wb_sel, sel_use;
    logic [31:0] wb_dat, wb_q, rd;
    logic [47:0] dst;
    logic [63:0] hw;
    mafpm_pkg::mafpm_rx_req_t rx_req;
    mafpm_pkg::mafpm_rx_res_t rx_res;
    mafpm_pkg::mafpm_mdio_drv_t mdio_drv;
    int num_errors = 0, samples_checked = 0, cyc_cnt = 0;
    int tgt[4] = '{0, 63, 31, 32};
    mafpm_top #(.DIV_HALF(4)) mafpm_top_inst (
        .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
        .wb_ack_o(wb_ack), .rx_req(rx_req), .rx_res(rx_res),
        .mdio_in(mdio_w), .mdio_drv(mdio_drv), .phy_access_busy(busy));
    mafpm_phy_model mafpm_phy_model_inst (.mdc(mdio_drv.mdc),
        .mdio_out(mdio_drv.mdio_out), .mdio_oe(mdio_drv.mdio_oe),
        .mdio_wire(mdio_w));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat} <=
            {2'h3, we, sel_use, a, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack !== 1'h1 && n < 40);
        rd = wb_q;
        {wb_cyc, wb_stb} <= 2'h0;
        if (n >= 40) num_errors++;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        wb(1'h0, a, 32'h0);
        check($sformatf("register %h", a), rd, exp);
    endtask
    // software keeps the poll-before-write discipline of the busy bit
    task automatic mgmt(input logic [31:0] c);
        int n;
        n = 0;
        wb(1'h1, 12'h114, c);
        wb(1'h0, 12'h114, 32'h0);
        check("busy at start", 32'(rd[0]), 32'h1);
        check("busy pin", 32'(busy), 32'h1);
        do begin
            wb(1'h0, 12'h114, 32'h0);
            n++;
        end while (rd[0] !== 1'h0 && n < 400);
        if (n >= 400) num_errors++;
        check("busy pin idle", 32'(busy), 32'h0);
    endtask
    task automatic rx(input logic [47:0] d, input logic exp);
        @(posedge core_clk);
        rx_req <= {1'h1, d};
        @(posedge core_clk);
        rx_req <= {1'h0, d};
        @(posedge core_clk);
        check("rx done", 32'(rx_res.done), 32'h1);
        check("rx accept", 32'(rx_res.accept), 32'(exp));
    endtask
    function automatic logic [5:0] hidx(input logic [47:0] d);
        logic [31:0] c;
        c = 32'hffff_ffff;
        for (int i = 0; i < 48; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 32'hedb8_8320 : 32'h0);
        return {c[0], c[1], c[2], c[3], c[4], c[5]};
    endfunction
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat} = '0;
        sel_use = 4'hf;
        rx_req = '0;
        arst_n = 1'h0;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'h1;
        rd_chk(12'h104, 32'h0000_ffff);
        rd_chk(12'h108, 32'hffff_ffff);
        rd_chk(12'h10c, 32'h0);
        rd_chk(12'h110, 32'h0);
        rd_chk(12'h114, 32'h0);
        rd_chk(12'h118, 32'h0);
        rd_chk(12'h200, 32'h0);
        $display("reset values done");
        wb(1'h1, 12'h108, 32'h7856_3412);
        wb(1'h1, 12'h104, 32'habcd_bc9a);
        rd_chk(12'h104, 32'h0000_bc9a);
        rd_chk(12'h108, 32'h7856_3412);
        rx(48'hbc9a_7856_3412, 1'h1);
        rx(48'h9abc_7856_3412, 1'h0);
        // a single byte lane must leave the other three bytes alone
        sel_use = 4'h2;
        wb(1'h1, 12'h108, 32'h0000_aa00);
        sel_use = 4'hf;
        rd_chk(12'h108, 32'h7856_aa12);
        $display("station address done");
        dst = 48'h0000_0000_0001;
        foreach (tgt[k]) begin
            while (hidx(dst) != 6'(tgt[k]))
                dst = dst + 48'h2;
            hw = 64'h1 << tgt[k];
            wb(1'h1, 12'h10c, hw[63:32]);
            wb(1'h1, 12'h110, hw[31:0]);
            rx(dst, 1'h1);
            check("hash index", 32'(rx_res.hash_idx), 32'(tgt[k]));
            wb(1'h1, 12'h10c, ~hw[63:32]);
            wb(1'h1, 12'h110, ~hw[31:0]);
            rx(dst, 1'h0);
            wb(1'h1, 12'h140, 32'h1);
            rx(dst, 1'h1);
            wb(1'h1, 12'h140, 32'h0);
        end
        $display("group filter done");
        wb(1'h1, 12'h118, 32'hffff_beef);
        rd_chk(12'h118, 32'h0000_beef);
        mgmt(32'h0000_0943);
        rd = 32'(mafpm_phy_model_inst.regs[5]);
        check("phy reg 5", rd, 32'h0000_beef);
        rd_chk(12'h114, 32'h0000_0942);
        wb(1'h1, 12'h118, 32'h0);
        mgmt(32'h0000_0941);
        rd_chk(12'h118, 32'h0000_beef);
        mgmt(32'h0000_09c1);
        rd_chk(12'h118, 32'h0000_c3a7);
        $display("phy management done");
        end_of_test();
    end
endmodule // mafpm_top_tb
`default_nettype wire

// *** logic/mafpm_pkg.sv ***
// constants and carrier types for the address filter and phy management block
`default_nettype none
package mafpm_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_ADDR_HIGH = 12'h104;
    localparam logic [11:0] OFS_ADDR_LOW = 12'h108;
    localparam logic [11:0] OFS_HASH_UPPER = 12'h10c;
    localparam logic [11:0] OFS_HASH_LOWER = 12'h110;
    localparam logic [11:0] OFS_MGMT_CMD = 12'h114;
    localparam logic [11:0] OFS_MGMT_VALUE = 12'h118;
    localparam logic [11:0] OFS_FILTER_CTRL = 12'h140;
    // reset values
    localparam logic [15:0] RST_ADDR_HIGH = 16'hffff;
    localparam logic [31:0] RST_ADDR_LOW = 32'hffff_ffff;
    localparam logic [31:0] RST_HASH = 32'h0000_0000;
    localparam logic [15:0] RST_MGMT_VALUE = 16'h0000;
    localparam logic [4:0] RST_FIELD5 = 5'h00;
    // management command and filter control fields
    localparam int CMD_PHY_ADDR_LSB = 11;
    localparam int CMD_REG_IDX_LSB = 6;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_BUSY_BIT = 0;
    localparam int FILT_PASS_ALL_BIT = 0;
    // management frame layout, bit positions counted from the first bit sent
    localparam logic [5:0] FRM_LAST_BIT = 6'h3f;
    localparam logic [5:0] FRM_TA_FIRST = 6'h2e;
    localparam logic [5:0] FRM_DATA_FIRST = 6'h30;
    localparam logic [31:0] FRM_PREAMBLE = 32'hffff_ffff;
    localparam logic [1:0] FRM_START = 2'h1;
    localparam logic [1:0] FRM_OP_WRITE = 2'h1;
    localparam logic [1:0] FRM_OP_READ = 2'h2;
    localparam logic [1:0] FRM_TA_WRITE = 2'h2;
    // crc
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
    localparam logic [31:0] CRC_POLY_REFL = 32'hedb8_8320;
    // timing: half period of the management clock
    localparam int CLK_MHZ = 200;
    localparam int MDC_HALF_NS = 200;
    localparam int MDC_HALF_CYC = (MDC_HALF_NS * CLK_MHZ + 999) / 1000;

    typedef enum {
        MG_IDLE,
        MG_RUN
    } mafpm_mg_state_t;

    typedef struct packed {
        logic valid;
        logic [47:0] dest;
    } mafpm_rx_req_t;

    typedef struct packed {
        logic done;
        logic accept;
        logic group;
        logic [5:0] hash_idx;
    } mafpm_rx_res_t;

    typedef struct packed {
        logic mdc;
        logic mdio_out;
        logic mdio_oe;
    } mafpm_mdio_drv_t;
endpackage
`default_nettype wire

// *** logic/mafpm_top.sv ***
// station address, group hash filter and phy management over wishbone
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RULE1] address high holds station address 47:32 in bits 15:0, rest reads 0
// [RULE2] address low holds station address 31:0, fully read and write
// [RULE3] first received octet is low byte 0, sixth is high byte 1
// [RULE4] six-bit index: top bit picks table word, five bits pick the bit
// [RULE5] index zero is lower word bit 0; all ones is upper word bit 31
// [RULE6] group frame accepted when chosen table bit is one, else rejected
// [RULE7] pass-all-group setting accepts every group frame, table ignored
// [RULE8] upper table register holds hash bits 63:32, lower holds 31:0
// [RULE9] software writes phy address one on every access
// [RULE10] register index field 10:6 selects the phy register
// [RULE11] write-select one writes value register to phy; zero reads into it
// [RULE12] software sets busy to start; device clears it when access ends
// [RULE13] software waits for busy zero before writing command or value
// [RULE14] value register stays unchanged by software during a phy write
// [RULE15] after a read completes, value bits 15:0 hold the phy data
// [RULE16] value register: 16-bit field in 15:0, upper bits read zero
// [RULE17] each access is a standard clause 22 management frame
// [RULE18] group hash index comes from crc-32 over destination address
// [RULE19] unicast destination is compared with programmed station address
module mafpm_top #(
    parameter int DIV_HALF = mafpm_pkg::MDC_HALF_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // receive path destination check
    input wire mafpm_pkg::mafpm_rx_req_t rx_req,
    output mafpm_pkg::mafpm_rx_res_t rx_res,
    // management pins
    input wire logic mdio_in,
    output mafpm_pkg::mafpm_mdio_drv_t mdio_drv,
    output logic phy_access_busy
);
    localparam int DIV_W = 8;

    // the divider counter must hold DIV_HALF - 1
    if (DIV_HALF < 1 || DIV_HALF >= (1 << DIV_W)) begin : g_bad_div
        $error("DIV_HALF out of range");
    end

    typedef struct packed {
        logic wb_ack;
        logic [31:0] wb_dat;
        logic [15:0] station_address_high;
        logic [31:0] station_address_low;
        logic [31:0] group_hash_upper;
        logic [31:0] group_hash_lower;
        logic accept_all_group_frames;
        logic [4:0] phy_addr;
        logic [4:0] phy_register_index;
        logic phy_write_select;
        logic phy_access_busy;
        logic [15:0] mgmt_value;
        mafpm_pkg::mafpm_mg_state_t mg;
        logic [DIV_W-1:0] div;
        logic [5:0] bit_cnt;
        logic [63:0] shreg;
        logic [15:0] rd_shreg;
        logic mdc;
        logic mdio_oe;
        logic [2:0] mdio_sync;
        logic mdio_filt;
        mafpm_pkg::mafpm_rx_res_t rx;
    } mafpm_state_t;

    mafpm_state_t state_ff;
    mafpm_state_t nxt_state;

    // byte-lane merge for wishbone select
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // reflected crc-32, octet 0 first, each octet lsb first
    function automatic logic [31:0] crc48(input logic [47:0] d);
        logic [31:0] c;
        c = mafpm_pkg::CRC_INIT;
        for (int i = 0; i < 48; i++) begin
            if (c[0] ^ d[i]) begin
                c = (c >> 1) ^ mafpm_pkg::CRC_POLY_REFL;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction

    logic [31:0] rx_crc;
    logic [5:0] rx_idx;
    logic rx_group;
    logic [63:0] hash_table;
    logic wb_req;
    logic [31:0] cmd_view;
    logic div_tick;

    assign rx_crc = crc48(rx_req.dest); // [RULE18]
    // top crc bits in msb-first order form the index
    generate
        for (genvar g = 0; g < 6; g++) begin : g_idx
            assign rx_idx[g] = rx_crc[5 - g]; // [RULE18]
        end
    endgenerate
    assign rx_group = rx_req.dest[0];
    assign hash_table = {state_ff.group_hash_upper,
                         state_ff.group_hash_lower}; // [RULE8]
    assign wb_req = wb_cyc_i && wb_stb_i && !state_ff.wb_ack;
    assign div_tick = (state_ff.div == DIV_W'(DIV_HALF - 1));
    assign cmd_view = {16'h0000,
                       state_ff.phy_addr,
                       state_ff.phy_register_index,
                       4'h0,
                       state_ff.phy_write_select,
                       state_ff.phy_access_busy};

    always_comb begin
        nxt_state = state_ff;
        nxt_state.wb_ack = wb_req;
        nxt_state.rx.done = 1'b0;
        nxt_state.mdio_sync = {state_ff.mdio_sync[1:0], mdio_in};
        // a pin change counts once the second and third stages agree
        if (state_ff.mdio_sync[1] == state_ff.mdio_sync[2]) begin
            nxt_state.mdio_filt = state_ff.mdio_sync[2];
        end

        // wishbone access, answered one cycle after the request
        if (wb_req) begin
            nxt_state.wb_dat = 32'h0000_0000;
            case (wb_adr_i)
                mafpm_pkg::OFS_ADDR_HIGH: begin
                    nxt_state.wb_dat = {16'h0000,
                        state_ff.station_address_high}; // [RULE1]
                    if (wb_we_i) begin
                        nxt_state.station_address_high = 16'(lane_merge(
                            {16'h0000, state_ff.station_address_high},
                            wb_dat_i, wb_sel_i)); // [RULE1]
                    end
                end
                mafpm_pkg::OFS_ADDR_LOW: begin
                    nxt_state.wb_dat = state_ff.station_address_low;
                    if (wb_we_i) begin
                        nxt_state.station_address_low = lane_merge(
                            state_ff.station_address_low,
                            wb_dat_i, wb_sel_i); // [RULE2]
                    end
                end
                mafpm_pkg::OFS_HASH_UPPER: begin
                    nxt_state.wb_dat = state_ff.group_hash_upper;
                    if (wb_we_i) begin
                        nxt_state.group_hash_upper = lane_merge(
                            state_ff.group_hash_upper,
                            wb_dat_i, wb_sel_i); // [RULE8]
                    end
                end
                mafpm_pkg::OFS_HASH_LOWER: begin
                    nxt_state.wb_dat = state_ff.group_hash_lower;
                    if (wb_we_i) begin
                        nxt_state.group_hash_lower = lane_merge(
                            state_ff.group_hash_lower,
                            wb_dat_i, wb_sel_i); // [RULE8]
                    end
                end
                mafpm_pkg::OFS_MGMT_CMD: begin
                    nxt_state.wb_dat = cmd_view;
                    // writes while busy are dropped so a running frame
                    // cannot be corrupted
                    if (wb_we_i && !state_ff.phy_access_busy) begin // [RULE13]
                        if (wb_sel_i[1]) begin
                            nxt_state.phy_addr = wb_dat_i[
                                mafpm_pkg::CMD_PHY_ADDR_LSB +: 5];
                        end
                        if (wb_sel_i[0] && wb_sel_i[1]) begin
                            nxt_state.phy_register_index = wb_dat_i[
                                mafpm_pkg::CMD_REG_IDX_LSB +: 5]; // [RULE10]
                        end
                        if (wb_sel_i[0]) begin
                            nxt_state.phy_write_select = wb_dat_i[
                                mafpm_pkg::CMD_WRITE_BIT]; // [RULE11]
                            nxt_state.phy_access_busy = wb_dat_i[
                                mafpm_pkg::CMD_BUSY_BIT]; // [RULE12]
                        end
                    end
                end
                mafpm_pkg::OFS_MGMT_VALUE: begin
                    nxt_state.wb_dat = {16'h0000, state_ff.mgmt_value};
                    if (wb_we_i && !state_ff.phy_access_busy) begin // [RULE14]
                        nxt_state.mgmt_value = 16'(lane_merge(
                            {16'h0000, state_ff.mgmt_value},
                            wb_dat_i, wb_sel_i)); // [RULE16]
                    end
                end
                mafpm_pkg::OFS_FILTER_CTRL: begin
                    nxt_state.wb_dat = {31'h0000_0000,
                        state_ff.accept_all_group_frames};
                    if (wb_we_i && wb_sel_i[0]) begin
                        nxt_state.accept_all_group_frames = wb_dat_i[
                            mafpm_pkg::FILT_PASS_ALL_BIT];
                    end
                end
                default: begin
                    nxt_state.wb_dat = 32'h0000_0000;
                end
            endcase
        end

        // management frame engine
        case (state_ff.mg)
            mafpm_pkg::MG_IDLE: begin
                nxt_state.div = '0;
                nxt_state.mdc = 1'b0;
                nxt_state.mdio_oe = 1'b0;
                if (state_ff.phy_access_busy) begin // [RULE12]
                    nxt_state.mg = mafpm_pkg::MG_RUN;
                    nxt_state.bit_cnt = '0;
                    nxt_state.mdio_oe = 1'b1;
                    nxt_state.shreg = {mafpm_pkg::FRM_PREAMBLE,
                        mafpm_pkg::FRM_START,
                        state_ff.phy_write_select ? mafpm_pkg::FRM_OP_WRITE
                                                  : mafpm_pkg::FRM_OP_READ,
                        state_ff.phy_addr,
                        state_ff.phy_register_index,
                        mafpm_pkg::FRM_TA_WRITE,
                        state_ff.mgmt_value}; // [RULE17] [RULE10] [RULE11]
                end
            end
            mafpm_pkg::MG_RUN: begin
                nxt_state.div = div_tick ? '0 : state_ff.div + 1'b1;
                if (div_tick && !state_ff.mdc) begin
                    nxt_state.mdc = 1'b1;
                    // the phy drives read data after the turnaround
                    if (!state_ff.phy_write_select &&
                        state_ff.bit_cnt >= mafpm_pkg::FRM_DATA_FIRST) begin
                        nxt_state.rd_shreg = {state_ff.rd_shreg[14:0],
                                              state_ff.mdio_filt};
                    end
                end else if (div_tick) begin
                    nxt_state.mdc = 1'b0;
                    if (state_ff.bit_cnt == mafpm_pkg::FRM_LAST_BIT) begin
                        nxt_state.mg = mafpm_pkg::MG_IDLE;
                        nxt_state.mdio_oe = 1'b0;
                        nxt_state.phy_access_busy = 1'b0; // [RULE12]
                        if (!state_ff.phy_write_select) begin
                            nxt_state.mgmt_value =
                                state_ff.rd_shreg; // [RULE15]
                        end
                    end else begin
                        nxt_state.bit_cnt = state_ff.bit_cnt + 1'b1;
                        nxt_state.shreg = {state_ff.shreg[62:0], 1'b0};
                        // release the line from turnaround onward on reads
                        nxt_state.mdio_oe = state_ff.phy_write_select ||
                            (state_ff.bit_cnt + 1'b1 <
                             mafpm_pkg::FRM_TA_FIRST); // [RULE11]
                    end
                end
            end
            default: begin
                nxt_state.mg = mafpm_pkg::MG_IDLE;
            end
        endcase

        // destination address decision, one cycle after the request
        if (rx_req.valid) begin
            nxt_state.rx.done = 1'b1;
            nxt_state.rx.group = rx_group;
            nxt_state.rx.hash_idx = rx_idx; // [RULE4] [RULE5]
            if (rx_group) begin
                nxt_state.rx.accept = state_ff.accept_all_group_frames ||
                    hash_table[rx_idx]; // [RULE6] [RULE7]
            end else begin
                nxt_state.rx.accept = rx_req.dest ==
                    {state_ff.station_address_high,
                     state_ff.station_address_low}; // [RULE19] [RULE3]
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= '0;
            state_ff.station_address_high <= mafpm_pkg::RST_ADDR_HIGH;
            state_ff.station_address_low <= mafpm_pkg::RST_ADDR_LOW;
            state_ff.group_hash_upper <= mafpm_pkg::RST_HASH;
            state_ff.group_hash_lower <= mafpm_pkg::RST_HASH;
            state_ff.phy_addr <= mafpm_pkg::RST_FIELD5;
            state_ff.phy_register_index <= mafpm_pkg::RST_FIELD5;
            state_ff.mgmt_value <= mafpm_pkg::RST_MGMT_VALUE;
            state_ff.mg <= mafpm_pkg::MG_IDLE;
            state_ff.mdio_sync <= 3'h7;
            state_ff.mdio_filt <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wb_ack_o = state_ff.wb_ack;
    assign wb_dat_o = state_ff.wb_dat;
    assign rx_res = state_ff.rx;
    assign mdio_drv.mdc = state_ff.mdc;
    assign mdio_drv.mdio_out = state_ff.shreg[63];
    assign mdio_drv.mdio_oe = state_ff.mdio_oe;
    assign phy_access_busy = state_ff.phy_access_busy;
endmodule // mafpm_top
`default_nettype wire
